//--- rtl/tpd_device.sv
// tamper peak detect: metering device end, low power comparator path
// assumes power select pins arrive from another party and are resynchronised here
`timescale 1ns/1ps
module tpd_device #(
    parameter int unsigned TICK = tpd_pkg::TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    tpd_if.device link,
    input wire logic [tpd_pkg::CUR_W-1:0] phase_a_current,
    input wire logic [tpd_pkg::CUR_W-1:0] phase_b_current,
    input wire logic [tpd_pkg::CUR_W-1:0] phase_c_current,
    input wire logic [tpd_pkg::CUR_W-1:0] full_scale,
    output logic [1:0] power_mode,
    output logic core_power_on,
    output logic detect_done
);
    import tpd_pkg::*;
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] sel_s1;
        logic [1:0] sel_s2;
        tpd_mode_t mode;
        logic [WIN_W-1:0] win_cfg;
        logic [LVL_W-1:0] lvl_cfg;
        logic [NCH-1:0] above;
        logic [NCH*CNT_W-1:0] peaks;
        logic [31:0] tick_cnt;
        logic [WIN_W+2:0] ticks;
        logic done;
        logic no_tamper_n;
        logic tamper_n;
        logic core_on;
    } tpd_dev_state_t;
    tpd_dev_state_t st;
    tpd_dev_state_t next_st;
    logic [NCH*CUR_W-1:0] cur;
    logic [CUR_W+RATIO_W-1:0] scaled [NCH];
    logic [NCH-1:0] over;
    logic any_hit;
    assign cur = {phase_c_current, phase_b_current, phase_a_current};
    // ------------------------------------------------------------
    // comparator: current above full_scale / ratio
    // ------------------------------------------------------------
    // compare by multiplication to avoid a divider in the low power path
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_cmp
            assign scaled[g] = cur[g*CUR_W +: CUR_W] * tpd_ratio(st.lvl_cfg);
            assign over[g] = scaled[g] > {{RATIO_W{1'b0}}, full_scale};
        end
    endgenerate
    always_comb begin
        any_hit = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            if (st.peaks[i*CNT_W +: CNT_W] >= CNT_W'({1'b0, st.win_cfg} + 5'h01)) begin
                any_hit = 1'b1;
            end
        end
    end
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.sel_s1 = {link.power_sel_hi, link.power_sel_lo};
        next_st.sel_s2 = st.sel_s1;
        case (st.sel_s2)
            SEL_NORMAL: next_st.mode = normal_run_state;
            SEL_MEASURE: next_st.mode = tamper_measure_state;
            SEL_DETECT: next_st.mode = tamper_detect_state;
            default: next_st.mode = idle_state;
        endcase
        // config only accepted while the core is alive
        if (link.cfg_write && (st.mode == normal_run_state || st.mode == tamper_measure_state)) begin
            next_st.win_cfg = link.detect_window_count;
            next_st.lvl_cfg = link.peak_threshold_select;
        end
        next_st.core_on = (next_st.mode != tamper_detect_state) && (next_st.mode != idle_state);
        if (next_st.mode == tamper_detect_state && st.mode != tamper_detect_state) begin
            next_st.peaks = '0;
            next_st.above = '0;
            next_st.tick_cnt = '0;
            next_st.ticks = '0;
            next_st.done = 1'b0;
            next_st.no_tamper_n = 1'b1;
            next_st.tamper_n = 1'b1;
        end else if (st.mode == tamper_detect_state && !st.done) begin
            next_st.above = over;
            for (int i = 0; i < NCH; i++) begin
                // a peak is a rising crossing; saturate to keep counts sane
                if (over[i] && !st.above[i] && st.peaks[i*CNT_W +: CNT_W] != 5'h1f) begin
                    next_st.peaks[i*CNT_W +: CNT_W] = st.peaks[i*CNT_W +: CNT_W] + 5'h01;
                end
            end
            if (st.tick_cnt == TICK - 1) begin
                next_st.tick_cnt = '0;
                next_st.ticks = st.ticks + 7'h01;
            end else begin
                next_st.tick_cnt = st.tick_cnt + 32'h1;
            end
            if (st.ticks == 7'({3'h0, st.win_cfg} + 7'(WINDOW_BIAS))) begin
                next_st.done = 1'b1;
                next_st.tamper_n = !any_hit;
                next_st.no_tamper_n = any_hit;
            end
        end
        if (next_st.mode != tamper_detect_state) begin
            next_st.no_tamper_n = 1'b1;
            next_st.tamper_n = 1'b1;
        end
    end
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '{sel_s1: SEL_NORMAL, sel_s2: SEL_NORMAL, mode: normal_run_state,
                    win_cfg: WIN_RESET, lvl_cfg: LVL_RESET, above: '0, peaks: '0,
                    tick_cnt: '0, ticks: '0, done: 1'b0, no_tamper_n: 1'b1,
                    tamper_n: 1'b1, core_on: 1'b1};
        end else begin
            st <= next_st;
        end
    end
    assign link.no_tamper_flag_n = st.no_tamper_n;
    assign link.tamper_flag_n = st.tamper_n;
    assign power_mode = st.mode;
    assign core_power_on = st.core_on;
    assign detect_done = st.done;
endmodule

//--- rtl/tpd_host.sv
// tamper peak detect: host controller end, with AXI4-Lite registers
// assumes flags come from the device pins and are resynchronised here
`timescale 1ns/1ps
module tpd_host #(
    parameter int unsigned TICK = tpd_pkg::TICK_CYCLES,
    parameter longint unsigned IDLE = tpd_pkg::IDLE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    tpd_if.host link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    import tpd_pkg::*;
    // ------------------------------------------------------------
    // register map: ctrl 0x0, status 0x4, irq status 0x8, mask 0xc
    // ------------------------------------------------------------
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_STAT = 4'h4;
    localparam logic [3:0] A_IST = 4'h8;
    localparam logic [3:0] A_MASK = 4'hc;
    typedef enum logic [2:0] {h_normal, h_config, h_detect, h_idle, h_measure} tpd_hst_t;
    typedef struct packed {
        logic [1:0] f1;
        logic [1:0] f2;
        tpd_hst_t fsm;
        logic [32:0] wait_cnt;
        logic [31:0] span;
        logic run;
        logic [WIN_W-1:0] win;
        logic [LVL_W-1:0] lvl;
        logic [2:0] ist;
        logic [2:0] mask;
        logic cfg_wr;
        logic [1:0] sel;
        logic aw_got;
        logic w_got;
        logic [3:0] aw_addr;
        logic [31:0] wd;
        logic bvalid;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] bresp;
        logic irq;
    } tpd_host_state_t;
    tpd_host_state_t st;
    tpd_host_state_t next_st;
    logic [31:0] detect_span;
    // settle window plus one tick margin, counted in aclk cycles
    assign detect_span = ({28'h0, st.win} + 32'(WINDOW_BIAS) + 32'h1) * 32'(TICK);
    always_comb begin
        next_st = st;
        next_st.f1 = {link.tamper_flag_n, link.no_tamper_flag_n};
        next_st.f2 = st.f1;
        next_st.cfg_wr = 1'b0;
        // ------------------------------------------------------------
        // AXI4-Lite slave
        // ------------------------------------------------------------
        if (s_axi_awvalid && !st.aw_got && !st.bvalid) begin
            next_st.aw_got = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_got && !st.bvalid) begin
            next_st.w_got = 1'b1;
            next_st.wd = s_axi_wdata;
        end
        if (st.aw_got && st.w_got) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = 2'h0;
            case (st.aw_addr)
                A_CTRL: begin
                    next_st.run = st.wd[0];
                    // clamp keeps the window count legal
                    next_st.win = (st.wd[7:4] > WIN_MAX) ? WIN_MAX : st.wd[7:4];
                    next_st.lvl = st.wd[11:8];
                end
                A_IST: next_st.ist = st.ist & ~st.wd[2:0];
                A_MASK: next_st.mask = st.wd[2:0];
                A_STAT: next_st.bresp = 2'h0;
                default: next_st.bresp = 2'h2;
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = 2'h0;
            case (s_axi_araddr)
                A_CTRL: next_st.rdata = {20'h0, st.lvl, st.win, 3'h0, st.run};
                A_STAT: next_st.rdata = {26'h0, st.f2, 1'b0, st.fsm};
                A_IST: next_st.rdata = {29'h0, st.ist};
                A_MASK: next_st.rdata = {29'h0, st.mask};
                default: begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = 2'h2;
                end
            endcase
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        // ------------------------------------------------------------
        // mode sequencer
        // ------------------------------------------------------------
        next_st.wait_cnt = st.wait_cnt + 33'h1;
        case (st.fsm)
            h_normal: begin
                next_st.sel = SEL_NORMAL;
                if (st.run) begin
                    next_st.fsm = h_config;
                end
            end
            h_config: begin
                next_st.cfg_wr = 1'b1;
                next_st.span = detect_span;
                next_st.wait_cnt = '0;
                next_st.fsm = h_detect;
            end
            h_detect: begin
                next_st.sel = SEL_DETECT;
                if (st.wait_cnt >= {1'b0, st.span}) begin
                    next_st.wait_cnt = '0;
                    if (!st.f2[1]) begin
                        next_st.ist[0] = 1'b1;
                        next_st.fsm = h_measure;
                    end else begin
                        next_st.ist[1] = 1'b1;
                        next_st.fsm = h_idle;
                    end
                end
            end
            h_idle: begin
                next_st.sel = SEL_IDLE;
                if (st.wait_cnt >= 33'(IDLE - 64'h1)) begin
                    next_st.wait_cnt = '0;
                    next_st.fsm = st.run ? h_detect : h_normal;
                end
            end
            h_measure: begin
                next_st.sel = SEL_MEASURE;
                if (!st.run) begin
                    next_st.ist[2] = 1'b1;
                    next_st.fsm = h_normal;
                end
            end
            default: next_st.fsm = h_normal;
        endcase
        next_st.irq = |(next_st.ist & next_st.mask);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            // flag synchronisers start at the released high level
            st.f1 <= 2'h3;
            st.f2 <= 2'h3;
        end else begin
            st <= next_st;
        end
    end
    assign link.power_sel_hi = st.sel[1];
    assign link.power_sel_lo = st.sel[0];
    assign link.detect_window_count = st.win;
    assign link.peak_threshold_select = st.lvl;
    assign link.cfg_write = st.cfg_wr;
    assign s_axi_awready = !st.aw_got && !st.bvalid;
    assign s_axi_wready = !st.w_got && !st.bvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign irq = st.irq;
endmodule

//--- rtl/tpd_if.sv
// tamper peak detect: pins between host and metering device
// assumes both ends share aclk; the device samples the pins itself
`timescale 1ns/1ps
interface tpd_if;
    logic power_sel_hi;
    logic power_sel_lo;
    logic no_tamper_flag_n;
    logic tamper_flag_n;
    logic [tpd_pkg::WIN_W-1:0] detect_window_count;
    logic [tpd_pkg::LVL_W-1:0] peak_threshold_select;
    logic cfg_write;
    modport device (
        input power_sel_hi, power_sel_lo, detect_window_count, peak_threshold_select, cfg_write,
        output no_tamper_flag_n, tamper_flag_n
    );
    modport host (
        output power_sel_hi, power_sel_lo, detect_window_count, peak_threshold_select, cfg_write,
        input no_tamper_flag_n, tamper_flag_n
    );
endinterface

//--- rtl/tpd_pkg.sv
// tamper peak detect: shared constants, pin codes and config layout
// assumes a 100 MHz aclk on both ends
package tpd_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned WINDOW_DIV = 50;
    localparam int unsigned WINDOW_BIAS = 4;
    localparam int unsigned TICK_CYCLES = CLK_HZ / WINDOW_DIV;
    localparam int unsigned IDLE_SECONDS = 60;
    // a minute of aclk cycles does not fit in 32 bits
    localparam longint unsigned IDLE_CYCLES = 64'(CLK_HZ) * 64'(IDLE_SECONDS);
    // ------------------------------------------------------------
    // config fields
    // ------------------------------------------------------------
    localparam int WIN_W = 4;
    localparam int LVL_W = 4;
    localparam logic [WIN_W-1:0] WIN_MAX = 4'ha;
    localparam logic [WIN_W-1:0] WIN_RESET = 4'h0;
    localparam logic [LVL_W-1:0] LVL_RESET = 4'h0;
    localparam int CUR_W = 16;
    localparam int RATIO_W = 11;
    localparam int CNT_W = 5;
    localparam int NCH = 3;
    // ------------------------------------------------------------
    // power select pin patterns {hi, lo}
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_NORMAL = 2'h0;
    localparam logic [1:0] SEL_MEASURE = 2'h1;
    localparam logic [1:0] SEL_DETECT = 2'h2;
    localparam logic [1:0] SEL_IDLE = 2'h3;
    typedef enum logic [1:0] {
        normal_run_state,
        tamper_measure_state,
        tamper_detect_state,
        idle_state
    } tpd_mode_t;
    // threshold ratio for each select code
    function automatic logic [RATIO_W-1:0] tpd_ratio(input logic [LVL_W-1:0] code);
        logic [RATIO_W-1:0] r;
        r = 11'h090;
        case (code)
            4'h0: r = 11'd144;
            4'h1: r = 11'd271;
            4'h2: r = 11'd377;
            4'h3: r = 11'd498;
            4'h4: r = 11'd578;
            4'h5: r = 11'd660;
            4'h6: r = 11'd764;
            4'h7: r = 11'd845;
            4'h8: r = 11'd970;
            4'h9: r = 11'd1100;
            4'ha: r = 11'd1196;
            4'hb: r = 11'd1312;
            4'hc: r = 11'd1371;
            4'hd: r = 11'd1464;
            4'he: r = 11'd1559;
            default: r = 11'd1629;
        endcase
        return r;
    endfunction
endpackage

//--- verif/test_tamper_peak_detect_modes.sv
// tamper peak detect: bench joining host and device over the pin interface
// assumes short TICK on both ends and a short host IDLE
`timescale 1ns/1ps
module test_tamper_peak_detect_modes;
    import tpd_pkg::*;
    localparam int unsigned TK = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] cur [3] = '{16'h0, 16'h0, 16'h0};
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, core_power_on, detect_done;
    logic [1:0] bresp, rresp, power_mode;
    logic [31:0] rdata;
    int miscompares = 0;
    int cmp_count = 0;
    int i;
    int unsigned ratio [16] = '{144, 271, 377, 498, 578, 660, 764, 845, 970, 1100, 1196, 1312, 1371, 1464, 1559, 1629};
    always #5 aclk = ~aclk;
    // ----------------------------------------
    // ends and checker
    // ----------------------------------------
    tpd_if link ();
    tpd_device #(.TICK(TK)) tpd_device_i (
        .aclk(aclk), .aresetn(aresetn), .link(link), .phase_a_current(cur[0]), .phase_b_current(cur[1]),
        .phase_c_current(cur[2]), .full_scale(16'h1000), .power_mode(power_mode),
        .core_power_on(core_power_on), .detect_done(detect_done));
    tpd_host #(.TICK(TK), .IDLE(100)) tpd_host_i (
        .aclk(aclk), .aresetn(aresetn), .link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    tpd_sva #(.TICK(TK)) tpd_sva_i (
        .aclk(aclk), .aresetn(aresetn), .power_sel_hi(link.power_sel_hi), .power_sel_lo(link.power_sel_lo),
        .no_tamper_flag_n(link.no_tamper_flag_n), .tamper_flag_n(link.tamper_flag_n),
        .detect_window_count(link.detect_window_count), .peak_threshold_select(link.peak_threshold_select),
        .cfg_write(link.cfg_write));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic timed_out(input string what);
        miscompares++;
        $display("[FAIL] %s expected answer seen timeout", what);
        tally_and_finish();
    endtask
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) timed_out("write response");
        bready <= 1'b0;
        chk("write resp", 32'h0, 32'(bresp));
        // one edge passes so a following call never reassigns bready in this step
        @(posedge aclk);
    endtask
    task automatic axi_read(input logic [3:0] a, input logic [31:0] exp, input string what);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 50) timed_out("read data");
        rready <= 1'b0;
        chk(what, exp, rdata);
        chk("read resp", 32'h0, 32'(rresp));
        @(posedge aclk);
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // peaks are a high step of two cycles then two cycles low
    task automatic pulse(input int ch, input logic [15:0] amp, input int cnt);
        repeat (cnt) begin
            cur[ch] <= amp;
            repeat (2) @(posedge aclk);
            cur[ch] <= 16'h0;
            repeat (2) @(posedge aclk);
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic check_idle_regs();
        do_reset();
        chk("pins after reset", 32'h3, 32'({link.tamper_flag_n, link.no_tamper_flag_n}));
        chk("mode after reset", 32'h0, 32'(power_mode));
        axi_read(4'h4, 32'h30, "status after reset");
        axi_write(4'h0, 32'hf0);
        axi_read(4'h0, 32'ha0, "clamped window");
        axi_write(4'hc, 32'h7);
        axi_read(4'hc, 32'h7, "mask");
        axi_write(4'h8, 32'h7);
        axi_read(4'h8, 32'h0, "irq status");
        chk("irq", 32'h0, 32'(irq));
    endtask
    // pre peaks arrive before detection is entered and must not count
    task automatic run_check(input logic [3:0] win, input logic [3:0] lvl, input int ch, input logic [15:0] amp,
                             input int pre, input int cnt, input logic tamper);
        int n;
        int lim;
        do_reset();
        axi_write(4'hc, 32'h3);
        pulse(ch, amp, pre);
        axi_write(4'h0, {20'h0, lvl, win, 3'h0, 1'b1});
        for (n = 0; n < 100 && power_mode !== 2'h2; n++) @(posedge aclk);
        if (n == 100) timed_out("detect entry");
        chk("core power", 32'h0, 32'(core_power_on));
        pulse(ch, amp, cnt);
        lim = (int'(win) + 4) * TK;
        for (n = 4 * cnt; n < lim + 40 && detect_done !== 1'b1; n++) @(posedge aclk);
        if (n == lim + 40) timed_out("verdict");
        chk("window length", 32'h1, 32'(n + 2 >= lim && n <= lim + 10));
        @(posedge aclk);
        chk("tamper pin", 32'(!tamper), 32'(link.tamper_flag_n));
        chk("no tamper pin", 32'(tamper), 32'(link.no_tamper_flag_n));
        repeat (3) @(posedge aclk);
        axi_read(4'h4, {26'h0, !tamper, tamper, 1'b0, 3'h2}, "status in detect");
        for (n = 0; n < 50 && {link.power_sel_hi, link.power_sel_lo} == SEL_DETECT; n++) @(posedge aclk);
        if (n == 50) timed_out("leave detect");
        chk("leave pattern", tamper ? 32'h1 : 32'h3, 32'({link.power_sel_hi, link.power_sel_lo}));
        axi_read(4'h8, tamper ? 32'h1 : 32'h2, "verdict event");
        chk("irq after verdict", 32'h1, 32'(irq));
        chk("mode after verdict", tamper ? 32'h1 : 32'h3, 32'(power_mode));
        chk("core after verdict", 32'(tamper), 32'(core_power_on));
    endtask
    initial begin
        check_idle_regs();
        run_check(4'h0, 4'h0, 0, 16'd29, 0, 1, 1'b1);
        run_check(4'h2, 4'h0, 1, 16'd29, 0, 2, 1'b0);
        run_check(4'h2, 4'h0, 2, 16'd29, 0, 3, 1'b1);
        run_check(4'ha, 4'h3, 0, 16'd9, 0, 11, 1'b1);
        run_check(4'ha, 4'h3, 1, 16'd9, 0, 10, 1'b0);
        run_check(4'h0, 4'h0, 1, 16'd29, 3, 0, 1'b0);
        for (i = 0; i < 16; i++) begin
            run_check(4'h0, i[3:0], i % 3, 16'(4096 / ratio[i]), 0, 1, 1'b0);
            run_check(4'h0, i[3:0], i % 3, 16'(4096 / ratio[i] + 1), 0, 1, 1'b1);
        end
        tally_and_finish();
    end
endmodule

//--- verif/tpd_sva.sv
// tamper peak detect: pin checker between host and device ends
// assumes one aclk and a synchronous active low aresetn
`timescale 1ns/1ps
module tpd_sva #(
    parameter int unsigned TICK = tpd_pkg::TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_sel_hi,
    input wire logic power_sel_lo,
    input wire logic no_tamper_flag_n,
    input wire logic tamper_flag_n,
    input wire logic [tpd_pkg::WIN_W-1:0] detect_window_count,
    input wire logic [tpd_pkg::LVL_W-1:0] peak_threshold_select,
    input wire logic cfg_write
);
    import tpd_pkg::*;
    // ----------------------------------------
    // helper: window figure and time in detect
    // ----------------------------------------
    logic [1:0] sel;
    logic [WIN_W-1:0] win_q;
    logic [31:0] det_cnt;
    logic [31:0] lim;
    assign sel = {power_sel_hi, power_sel_lo};
    assign lim = (32'(win_q) + 32'(WINDOW_BIAS)) * TICK;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_q <= WIN_RESET;
            det_cnt <= 32'h0;
        end else begin
            if (cfg_write) begin
                win_q <= detect_window_count;
            end
            det_cnt <= (sel == SEL_DETECT) ? det_cnt + 32'h1 : 32'h0;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_detect_armed;
        ##[1:2] (sel == SEL_DETECT);
    endsequence
    sequence s_left_on(logic flag_n);
        (sel == SEL_DETECT && !flag_n) ##1 (sel != SEL_DETECT);
    endsequence
    a_cfg_outside_detect: assert property (cfg_write |-> sel == SEL_NORMAL || sel == SEL_MEASURE)
        else $error("config pulse while detecting or idle");
    a_cfg_then_detect: assert property (cfg_write |-> s_detect_armed)
        else $error("detect pattern did not follow config pulse");
    a_win_in_range: assert property (cfg_write |-> detect_window_count <= WIN_MAX)
        else $error("window count above maximum");
    a_flags_exclusive: assert property (!(tamper_flag_n == 1'b0 && no_tamper_flag_n == 1'b0))
        else $error("both verdict pins low");
    a_no_early_verdict: assert property (sel == SEL_DETECT && det_cnt < lim |-> tamper_flag_n && no_tamper_flag_n)
        else $error("verdict before window end");
    a_verdict_by_deadline: assert property (det_cnt == lim + 32'd12 |-> tamper_flag_n != no_tamper_flag_n)
        else $error("no verdict after window end");
    a_verdict_holds: assert property (sel == SEL_DETECT && !(tamper_flag_n && no_tamper_flag_n)
        |=> $stable({tamper_flag_n, no_tamper_flag_n}))
        else $error("verdict changed while detecting");
    a_flags_released: assert property ((sel != SEL_DETECT) [*5] |-> tamper_flag_n && no_tamper_flag_n)
        else $error("verdict pin low outside detect");
    a_leave_on_tamper: assert property (s_left_on(tamper_flag_n) |-> sel == SEL_MEASURE)
        else $error("tamper not followed by measure pattern");
    a_leave_on_clear: assert property (s_left_on(no_tamper_flag_n) |-> sel == SEL_IDLE)
        else $error("clear verdict not followed by idle pattern");
endmodule
